// [inc/serial_channel_defs.svh]
`ifndef SERIAL_CHANNEL_DEFS_SVH
`define SERIAL_CHANNEL_DEFS_SVH

// register indices on the plain register port
`define REG_CONTROL    3'h0
`define REG_TXBUF      3'h1
`define REG_RXBUF      3'h2
`define REG_RELOAD     3'h3
`define REG_STATUS     3'h4

// control register field positions
`define CTL_RUN        15
`define CTL_LOOPBACK   14
`define CTL_BRS        13
`define CTL_ODD        12
`define CTL_OE         10
`define CTL_FE         9
`define CTL_PE         8
`define CTL_OEN        7
`define CTL_FEN        6
`define CTL_PEN        5
`define CTL_REN        4
`define CTL_STP        3
`define CTL_MODE_HI    2
`define CTL_MODE_LO    0

`define CONTROL_RESET  16'h0000
`define CONTROL_WMASK  16'hf7ff
`define RELOAD_RESET   13'h0000

// mode field encodings
`define MODE_SYNC      3'h0
`define MODE_8         3'h1
`define MODE_7P        3'h3
`define MODE_9         3'h4
`define MODE_8W        3'h5
`define MODE_8P        3'h7

// sixteen ticks per bit; majority of samples 7, 8 and 9
`define TICK_LAST      4'hf
`define SAMPLE_A       4'h7
`define SAMPLE_B       4'h8
`define SAMPLE_C       4'h9
`define SYNC_RISE      4'h8
`define BRS_DROP       2'h2

`endif

// [inc/serial_channel_pkg.sv]
package serial_channel_pkg;

  typedef struct packed {
    logic [2:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;

  typedef struct packed {
    logic [3:0] nd;
    logic       par;
    logic       wake;
    logic [3:0] total;
  } fmt_t;

  typedef enum logic {TX_IDLE, TX_SHIFT} tx_state_t;
  typedef enum logic {RX_IDLE, RX_SHIFT} rx_state_t;

endpackage

// [src/serial_channel.sv]
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "serial_channel_defs.svh"
// Behaviour
// [R1] writing transmit buffer starts a transmission
// [R2] only mode data bits sent; 9..15 ignored
// [R3] transmit buffer cleared after transmission completes
// [R4] double-buffered transmitter, back-to-back frames
// [R5] receive only when enabled; result in buffer
// [R6] unused upper receive buffer bits read zero
// [R7] double-buffered receiver
// [R8] overrun sets flag, error request, overwrites
// [R9] loop-back feeds transmit data to receiver
// [R10] nothing moves unless baud generator runs
// [R11] software never programs reserved mode encodings
// [R12] synchronous mode: 8-bit bytes, own shift clock
// [R13] least significant bit first always
// [R14] start, 8/9 data, one or two stops
// [R15] separate transmit, receive, error requests
// [R16] parity generated; checked only when enabled
// [R17] missing stop bits flagged when framing enabled
// [R18] synchronous reception clears receiver enable
// [R19] 8-bit frames: modes 001 and 011
// [R20] 9-bit frames: modes 100, 111, 101
// [R21] wake-up mode keeps only ninth-bit-one frames
// [R22] hardware sets error flags; software clears
module serial_channel
  import serial_channel_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire bus_req_t    bus,
  output logic [15:0]      rdata,
  input  wire logic        rxd,
  output logic             txd,
  output logic             sclk,
  output logic             tx_irq,
  output logic             rx_irq,
  output logic             err_irq
);

  function automatic fmt_t fmt_of(input logic [2:0] m, input logic two_stop);
    fmt_t f;
    f.nd   = 4'h8;
    f.par  = 1'b0;
    f.wake = 1'b0;
    case (m)
      `MODE_7P: f.par = 1'b1;                      // [R19]
      `MODE_9:  f.nd = 4'h9;                       // [R20]
      `MODE_8W:
      begin
        f.nd   = 4'h9;
        f.wake = 1'b1;
      end
      `MODE_8P:
      begin
        f.nd  = 4'h9;
        f.par = 1'b1;
      end
      default: ;                                   // reserved codes behave as 8-bit [R11]
    endcase
    f.total = (m == `MODE_SYNC) ? 4'h8 : f.nd + 4'h2 + {3'h0, two_stop}; // [R14] [R12]
    return f;
  endfunction

  // parity over the data bits below the parity position
  function automatic logic par_of(input logic [8:0] d, input logic [3:0] nd, input logic odd);
    logic x;
    x = 1'b0;
    for (int i = 0; i < 8; i++)
      if (4'(i) < nd - 4'h1)
        x = x ^ d[i];
    return x ^ odd;
  endfunction

  function automatic logic [8:0] mask_of(input logic [3:0] nd);
    return 9'h1ff >> (4'h9 - nd);
  endfunction

  logic [15:0] ctrl;
  logic [15:0] next_ctrl;
  logic [12:0] reload;
  logic [12:0] bcnt;
  logic [1:0]  bdiv3;
  tx_state_t   tx_state;
  rx_state_t   rx_state;
  logic [11:0] tsh;
  logic [3:0]  ttick;
  logic [3:0]  tbits;
  logic        tx_was;
  logic        sync_rx;
  logic [7:0]  ssh;
  logic [15:0] tbuf;
  logic        tx_full;
  logic [3:0]  rtick;
  logic [3:0]  ridx;
  logic [1:0]  samp;
  logic [8:0]  rsh;
  logic        stop_bad;
  logic        rx_prev;
  logic [8:0]  rbuf;
  logic        rx_full;
  logic [11:0] tx_frame;
  logic [8:0]  tx_data;
  logic [15:0] rd_word;

  wire       run       = ctrl[`CTL_RUN];
  wire       ren       = ctrl[`CTL_REN];
  wire [2:0] mode      = ctrl[`CTL_MODE_HI:`CTL_MODE_LO];
  wire       is_sync   = mode == `MODE_SYNC;
  wire fmt_t fmt       = fmt_of(mode, ctrl[`CTL_STP]);
  wire       rx_in     = ctrl[`CTL_LOOPBACK] ? txd : rxd;            // [R9]

  wire       wr_ctrl   = bus.wr && bus.addr == `REG_CONTROL;
  wire       wr_tbuf   = bus.wr && bus.addr == `REG_TXBUF;
  wire       wr_reload = bus.wr && bus.addr == `REG_RELOAD;
  wire       rd_rbuf   = bus.rd && bus.addr == `REG_RXBUF;

  // baud tick at sixteen times the bit rate
  wire       raw_tick  = run && bcnt == 13'h0000;
  wire       tick      = raw_tick && !(ctrl[`CTL_BRS] && bdiv3 == `BRS_DROP);

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      bcnt  <= `RELOAD_RESET;
      bdiv3 <= 2'h0;
    end
    else if (!run)
    begin
      bcnt  <= reload;
      bdiv3 <= 2'h0;
    end
    else
    begin
      bcnt <= raw_tick ? reload : bcnt - 13'h0001;
      if (raw_tick)
        bdiv3 <= (bdiv3 == `BRS_DROP) ? 2'h0 : bdiv3 + 2'h1;
    end
  end

  // transmitter
  wire tx_shift  = tx_state == TX_SHIFT;
  wire bit_end   = tick && tx_shift && ttick == `TICK_LAST;
  wire last_end  = bit_end && tbits == 4'h1;
  wire sync_done = last_end && sync_rx;
  wire sync_req  = is_sync && ren && !sync_done;
  wire start_ok  = run && (tx_full || sync_req);                      // [R1] [R10]
  wire can_load  = tick && (!tx_shift || last_end) && start_ok;     // [R4]

  always_comb
  begin
    tx_frame = 12'hfff;
    tx_data  = tbuf[8:0] & mask_of(fmt.nd);                          // [R2]
    if (fmt.par)
      tx_data[fmt.nd - 4'h1] = par_of(tbuf[8:0], fmt.nd, ctrl[`CTL_ODD]); // [R16]
    if (is_sync)
      tx_frame[7:0] = tx_full ? tbuf[7:0] : 8'hff;                  // [R12]
    else
    begin
      tx_frame[0]   = 1'b0;                                          // [R14]
      tx_frame[9:1] = tx_data | ~mask_of(fmt.nd);
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_state <= TX_IDLE;
      tsh      <= 12'hfff;
      ttick    <= 4'h0;
      tbits    <= 4'h0;
      tx_was   <= 1'b0;
      sync_rx  <= 1'b0;
      ssh      <= 8'h00;
      sclk     <= 1'b1;
      tx_irq   <= 1'b0;
    end
    else if (!run)
    begin
      tx_state <= TX_IDLE;                                           // [R10]
      tsh      <= 12'hfff;
      sclk     <= 1'b1;
      tx_irq   <= 1'b0;
    end
    else
    begin
      tx_irq <= bit_end && tbits == 4'h2 && tx_was;                  // [R15]
      sclk   <= (tx_shift && is_sync) ? ttick[3] : 1'b1;
      if (can_load)
      begin
        tx_state <= TX_SHIFT;
        tsh      <= tx_frame;
        tbits    <= fmt.total;
        ttick    <= 4'h0;
        tx_was   <= tx_full;
        sync_rx  <= sync_req;
      end
      else if (last_end)
      begin
        tx_state <= TX_IDLE;
        tsh      <= 12'hfff;
      end
      else if (tick && tx_shift)
      begin
        ttick <= ttick + 4'h1;
        if (bit_end)
        begin
          tsh   <= {1'b1, tsh[11:1]};                                // [R13]
          tbits <= tbits - 4'h1;
        end
      end
      if (tick && tx_shift && is_sync && ttick == `SYNC_RISE)
        ssh <= {rx_in, ssh[7:1]};                                    // [R13]
    end
  end

  assign txd = tsh[0];

  // the buffer keeps the moved word until its frame ends, then clears unless another word was written meanwhile
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tbuf    <= 16'h0000;
      tx_full <= 1'b0;
    end
    else if (wr_tbuf)
    begin
      tbuf    <= bus.wdata;                                          // [R1]
      tx_full <= 1'b1;
    end
    else
    begin
      if (can_load)
        tx_full <= 1'b0;                                             // [R4]
      if (last_end && tx_was && !tx_full)
        tbuf <= 16'h0000;                                            // [R3]
    end
  end

  // asynchronous receiver
  wire rx_samp   = tick && rx_state == RX_SHIFT && rtick == `SAMPLE_C;
  wire rx_bit    = (samp[0] & samp[1]) | (samp[0] & rx_in) | (samp[1] & rx_in);
  wire start_bad = rx_samp && ridx == 4'h0 && rx_bit;
  wire rx_last   = rx_samp && ridx == fmt.total - 4'h1;
  wire rx_go     = run && ren && !is_sync && rx_state == RX_IDLE && rx_prev && !rx_in; // [R5]

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_state <= RX_IDLE;
      rtick    <= 4'h0;
      ridx     <= 4'h0;
      samp     <= 2'h0;
      rsh      <= 9'h000;
      stop_bad <= 1'b0;
      rx_prev  <= 1'b1;
    end
    else
    begin
      rx_prev <= rx_in;
      if (!run || !ren || is_sync)
        rx_state <= RX_IDLE;                                         // [R10] [R5]
      else if (rx_go)
      begin
        rx_state <= RX_SHIFT;
        rtick    <= 4'h0;
        ridx     <= 4'h0;
        stop_bad <= 1'b0;
      end
      else if (tick && rx_state == RX_SHIFT)
      begin
        rtick <= rtick + 4'h1;
        if (rtick == `SAMPLE_A)
          samp[0] <= rx_in;
        if (rtick == `SAMPLE_B)
          samp[1] <= rx_in;
        if (rx_samp)
        begin
          ridx <= ridx + 4'h1;
          if (start_bad || rx_last)
            rx_state <= RX_IDLE;
          if (ridx != 4'h0 && ridx <= fmt.nd)
            rsh[ridx - 4'h1] <= rx_bit;                              // [R13]
          if (ridx > fmt.nd && !rx_bit)
            stop_bad <= 1'b1;
        end
      end
    end
  end

  // delivery into the receive buffer, shared by both modes
  wire       async_done = rx_last && !start_bad;
  wire       deliver    = (async_done && (!fmt.wake || rsh[8])) || sync_done; // [R21]
  wire [8:0] rx_word    = sync_done ? {1'b0, ssh} : rsh & mask_of(fmt.nd); // [R6]
  wire       set_pe     = async_done && deliver && ctrl[`CTL_PEN] && fmt.par &&
                          rsh[fmt.nd - 4'h1] != par_of(rsh, fmt.nd, ctrl[`CTL_ODD]); // [R16]
  wire       set_fe     = async_done && deliver && ctrl[`CTL_FEN] && (stop_bad || !rx_bit); // [R17]
  wire       set_oe     = deliver && ctrl[`CTL_OEN] && rx_full;     // [R8]

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rbuf    <= 9'h000;
      rx_full <= 1'b0;
      rx_irq  <= 1'b0;
      err_irq <= 1'b0;
    end
    else
    begin
      rx_irq  <= deliver;                                            // [R15]
      err_irq <= set_pe || set_fe || set_oe;                         // [R15] [R8]
      if (deliver)
      begin
        rbuf    <= rx_word;                                          // [R5] [R7] [R8]
        rx_full <= 1'b1;
      end
      else if (rd_rbuf)
        rx_full <= 1'b0;
    end
  end

  // control register: hardware sets win over a software write in the same cycle
  always_comb
  begin
    next_ctrl = ctrl;
    if (wr_ctrl)
      next_ctrl = bus.wdata & `CONTROL_WMASK;
    if (set_pe)
      next_ctrl[`CTL_PE] = 1'b1;                                     // [R22]
    if (set_fe)
      next_ctrl[`CTL_FE] = 1'b1;                                     // [R22]
    if (set_oe)
      next_ctrl[`CTL_OE] = 1'b1;                                     // [R22]
    if (sync_done && !wr_ctrl)
      next_ctrl[`CTL_REN] = 1'b0;                                    // [R18]
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl   <= `CONTROL_RESET;
      reload <= `RELOAD_RESET;
    end
    else
    begin
      ctrl <= next_ctrl;
      if (wr_reload)
        reload <= bus.wdata[12:0];
    end
  end

  // transmit buffer is write-only and reads as zero
  always_comb
  begin
    case (bus.addr)
      `REG_CONTROL: rd_word = ctrl;
      `REG_RXBUF:   rd_word = {7'h00, rbuf};                         // [R6]
      `REG_RELOAD:  rd_word = {3'h0, reload};
      `REG_STATUS:  rd_word = {12'h000, rx_state == RX_SHIFT, rx_full, tx_shift, tx_full};
      default:      rd_word = 16'h0000;
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rdata <= 16'h0000;
    else
      rdata <= bus.rd ? rd_word : 16'h0000;
  end

endmodule

// [verif/serial_channel_asserts.sv]
`timescale 1ns/1ps
module serial_channel_asserts
  import serial_channel_pkg::*;
(
  input wire logic        clk,
  input wire logic        resetn,
  input wire bus_req_t    bus,
  input wire logic [15:0] rdata,
  input wire logic        rxd,
  input wire logic        txd,
  input wire logic        sclk,
  input wire logic        tx_irq,
  input wire logic        rx_irq,
  input wire logic        err_irq
);
  logic       run;
  logic [2:0] mode;

  // only software writes these fields, so a shadow of the writes is exact
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      {run, mode} <= 4'h0;
    else if (bus.wr && bus.addr == 3'h0)
      {run, mode} <= {bus.wdata[15], bus.wdata[2:0]};

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  rdata_idle_a: assert property (!$past(bus.rd) |-> rdata == 16'h0)
    else $error("read data outside a read cycle");
  write_only_a: assert property (bus.rd && bus.addr == 3'h1 |=> rdata == 16'h0)
    else $error("transmit buffer readable");
  tx_pulse_a: assert property (tx_irq |=> !tx_irq)
    else $error("transmit request longer than one cycle");
  rx_pulse_a: assert property (rx_irq |=> !rx_irq)
    else $error("receive request longer than one cycle");
  err_pair_a: assert property (err_irq |-> rx_irq)
    else $error("error request without receive request");
  run_idle_a: assert property (!run && !$past(run) |-> txd && sclk)
    else $error("serial lines active while stopped");
  start_len_a: assert property ($fell(txd) |-> !txd [*8] ##8 !txd)
    else $error("first low cell shorter than one bit");
  stop_high_a: assert property (tx_irq && mode != 3'h0 |=> ##1 txd [*8])
    else $error("last bit not a stop bit");
  sclk_low_a: assert property ($fell(sclk) |-> !sclk [*8] ##1 sclk)
    else $error("shift clock low phase not eight ticks");
endmodule

// [verif/serial_peer.sv]
`timescale 1ns/1ps
module serial_peer (
  input wire logic clk,
  input wire logic txd,
  input wire logic sclk,
  output logic     rxd
);
  logic [8:0] got [$];
  time        ts [$];
  logic [8:0] f;
  logic [7:0] sb = 8'h0;

  initial rxd = 1'b1;

  // start, n data bits lsb first, one stop; bad forces the stop low
  task automatic send(input logic [8:0] d, input int n, input logic bad);
    @(posedge clk);
    for (int i = -1; i <= n; i++)
    begin
      rxd <= (i < 0) ? 1'b0 : (i == n) ? ~bad : d[i];
      repeat (16) @(posedge clk);
    end
    rxd <= 1'b1;
    repeat (16) @(posedge clk);
  endtask

  // nine cells sampled mid-bit: 8 data plus stop, or 9 data
  always
  begin
    @(negedge txd);
    ts.push_back($time);
    repeat (8) @(posedge clk);
    for (int i = 0; i < 9; i++)
    begin
      repeat (16) @(posedge clk);
      f[i] = txd;
    end
    got.push_back(f);
  end

  // synchronous data changes on the falling shift clock, ready for the rise
  always @(negedge sclk)
  begin
    rxd <= sb[0];
    sb <= sb >> 1;
  end
endmodule

// [verif/serial_channel_bench.sv]
`timescale 1ns/1ps
module serial_channel_bench
  import serial_channel_pkg::*;
;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  bus_req_t    bus = '0;
  logic [15:0] rdata;
  logic        rxd, txd, sclk, tx_irq, rx_irq, err_irq;
  int          n_mismatch = 0, check_count = 0, n_rx = 0, n_err = 0, n_tx = 0;

  always #12.5 clk = ~clk;

  serial_channel DUT (.clk, .resetn, .bus, .rdata, .rxd, .txd, .sclk, .tx_irq, .rx_irq, .err_irq);
  serial_peer peer (.clk, .txd, .sclk, .rxd);

  always @(posedge clk) n_rx += (rx_irq === 1'b1);
  always @(posedge clk) n_err += (err_irq === 1'b1);
  always @(posedge clk) n_tx += (tx_irq === 1'b1);

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_n(input int got, input int exp);
    check_count++;
    if (got != exp)
    begin
      n_mismatch++;
      $display("MISMATCH %0t count %0d expected %0d", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [15:0] exp);
    @(posedge clk);
    bus <= '{a, 16'h0, 1'b0, 1'b1};
    @(posedge clk);
    bus <= '0;
    #1 chk(rdata, exp);
  endtask

  task automatic wait_rx(input int n);
    for (int i = 0; i < 800 && n_rx < n; i++)
      @(posedge clk);
    chk_n(n_rx, n);
  endtask

  task automatic wait_got(input int n);
    for (int i = 0; i < 800 && peer.got.size() < n; i++)
      @(posedge clk);
    chk_n(peer.got.size(), n);
  endtask

  task automatic end_of_test;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // whole run is about 2700 cycles
  initial
  begin
    #400000;
    n_mismatch++;
    end_of_test;
  end

  initial
  begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    wr(5, 16'hffff);
    rd(0, 16'h0000);
    rd(1, 16'h0000);
    rd(5, 16'h0000);
    wr(3, 16'h0000);
    wr(0, 16'h8091);
    peer.send(9'h03c, 8, 1'b0);
    wait_rx(1);
    rd(2, 16'h003c);
    peer.send(9'h081, 8, 1'b0);
    peer.send(9'h042, 8, 1'b0);
    wait_rx(3);
    chk_n(n_err, 1);
    rd(0, 16'h8491);
    rd(2, 16'h0042);
    wr(0, 16'h80d1);
    peer.send(9'h055, 8, 1'b1);
    wait_rx(4);
    rd(0, 16'h82d1);
    rd(2, 16'h0055);
    wr(0, 16'h8037);
    peer.send(9'h10f, 9, 1'b0);
    wait_rx(5);
    rd(0, 16'h8137);
    rd(2, 16'h010f);
    wr(1, 16'h0007);
    wait_got(1);
    chk({7'h0, peer.got[0]}, 16'h0107);
    wr(0, 16'h8015);
    peer.send(9'h0aa, 9, 1'b0);
    peer.send(9'h1bb, 9, 1'b0);
    wait_rx(6);
    rd(2, 16'h01bb);
    // two stop bits, ren off: second write lands while the first shifts
    wr(0, 16'h8009);
    wr(1, 16'hfe5a);
    wr(1, 16'h00c3);
    rd(4, 16'h0003);
    peer.send(9'h011, 8, 1'b0);
    wait_got(3);
    chk({7'h0, peer.got[1]}, 16'h015a);
    chk({7'h0, peer.got[2]}, 16'h01c3);
    chk_n(int'(peer.ts[2] - peer.ts[1]), 4400);
    // the peer is done mid first stop; the request comes with the second stop
    repeat (32) @(posedge clk);
    chk_n(n_rx, 6);
    chk_n(n_tx, 3);
    wr(0, 16'h0003);
    wr(1, 16'h007f);
    repeat (400) @(posedge clk);
    chk_n(peer.got.size(), 3);
    wr(0, 16'h8003);
    wait_got(4);
    chk({7'h0, peer.got[3]}, 16'h01ff);
    wr(0, 16'hc014);
    wr(1, 16'h0199);
    wait_rx(7);
    rd(2, 16'h0199);
    peer.sb <= 8'hc6;
    wr(0, 16'h8010);
    wait_rx(8);
    rd(2, 16'h00c6);
    rd(0, 16'h8000);
    end_of_test;
  end
endmodule

bind serial_channel serial_channel_asserts chk_i (.clk, .resetn, .bus, .rdata, .rxd, .txd, .sclk, .tx_irq,
  .rx_irq, .err_irq);
